// >>> verilog/fast_data_port_a_regs.sv
// port a event enables, stream identifier filter and buffer routing behind an ahb-lite slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`include "fdp_consts.svh"

// How it works
// - with the insertion-done enable set, a hardware-set insertion-done flag raises the summary irq.
// - with the overflow enable set, a hardware-set overflow flag raises the summary irq.
// - a flag whose enable is clear never affects the summary irq.
// - only identifier bits set in the 32-bit mask take part in the location compare.
// - an all-zero mask compares nothing and every identifier passes.
// - each of locations 0 to 7 has a 3-bit buffer select, location n at bits 4n+2:4n.
// - with the filter on, a matching identifier is steered to that location's buffer.
// - reserved bits ignore writes and read back as zero.
// - an overfilled transmit buffer sets the overflow flag.
// - setting the insertion-done flag switches the inserter off until software re-enables it.
module fast_data_port_a_regs (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        STRM_VALID,
  input  wire logic [31:0] STRM_ID,
  input  wire logic        TX_OVERFLOW,
  input  wire logic        INSERT_DONE,
  output logic             ROUTE_VALID,
  output logic      [2:0]  ROUTE_BUF,
  output logic             ROUTE_HIT,
  output logic             INSERT_EN,
  output logic             FILTER_EN,
  output logic             SUMMARY_PORT_A_IRQ
);

  localparam logic [11:0] LOC_BASE = `OFS_LOC_BASE;

  fdp_pkg::state_t        st_ff;
  fdp_pkg::state_t        nxt_st;
  fdp_pkg::match_result_t match;
  logic                   accept;

  //////////////////////////////////////////////////////////////////////////////

  stream_id_matcher u_matcher (
    .stream_id (STRM_ID),
    .mask      (st_ff.mask),
    .loc_value (st_ff.loc_value),
    .result    (match)
  );

  function automatic logic is_loc(input logic [11:0] a);
    return a[11:5] == LOC_BASE[11:5];
  endfunction

  function automatic logic [31:0] read_word(input fdp_pkg::state_t s, input logic [11:0] a);
    logic [31:0] w;
    w = `UNMAPPED_READ;
    if (is_loc(a)) begin
      w = s.loc_value[a[4:2]];
    end else begin
      unique case (a)
        `OFS_EVENT_STATUS: begin
          w[`BIT_INSERT_DONE] = s.status.insertion_done;
          w[`BIT_TX_OVERFLOW] = s.status.tx_buffer_overflow;
        end
        `OFS_EVENT_ENABLE: begin
          w[`BIT_INSERT_DONE] = s.enable.insertion_done;
          w[`BIT_TX_OVERFLOW] = s.enable.tx_buffer_overflow;
        end
        `OFS_FILTER_MASK: w = s.mask;
        `OFS_BUFFER_MAP: begin
          for (int i = 0; i < 8; i++) begin
            w[i*`MAP_FIELD_STRIDE +: `MAP_FIELD_WIDTH] = s.buf_select[i];
          end
        end
        `OFS_FILTER_CTRL: begin
          w[`CTRL_FILTER_EN] = s.filter_en;
          w[`CTRL_INSERT_EN] = s.insert_en;
        end
        default: w = `UNMAPPED_READ;
      endcase
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  assign accept = HSEL && HREADY && HTRANS[1];

  always_comb begin
    nxt_st = st_ff;

    // register writes land in the data phase, one word per transfer
    if (st_ff.phase == fdp_pkg::BUS_WRITE) begin
      if (is_loc(st_ff.addr)) begin
        // locations are frozen while the filter runs, so a compare never sees a torn value
        if (!st_ff.filter_en) begin
          nxt_st.loc_value[st_ff.addr[4:2]] = HWDATA;
        end
      end else begin
        unique case (st_ff.addr)
          `OFS_EVENT_STATUS: begin
            if (HWDATA[`BIT_INSERT_DONE]) begin
              nxt_st.status.insertion_done = 1'b0;
            end
            if (HWDATA[`BIT_TX_OVERFLOW]) begin
              nxt_st.status.tx_buffer_overflow = 1'b0;
            end
          end
          `OFS_EVENT_ENABLE: begin
            nxt_st.enable.insertion_done     = HWDATA[`BIT_INSERT_DONE];
            nxt_st.enable.tx_buffer_overflow = HWDATA[`BIT_TX_OVERFLOW];
          end
          `OFS_FILTER_MASK: nxt_st.mask = HWDATA;
          `OFS_BUFFER_MAP: begin
            for (int i = 0; i < 8; i++) begin
              nxt_st.buf_select[i] = HWDATA[i*`MAP_FIELD_STRIDE +: `MAP_FIELD_WIDTH];
            end
          end
          `OFS_FILTER_CTRL: begin
            nxt_st.filter_en = HWDATA[`CTRL_FILTER_EN];
            nxt_st.insert_en = HWDATA[`CTRL_INSERT_EN];
          end
          default: ;
        endcase
      end
    end

    // bus phase sequencing; reads take one wait state so data comes from a flop
    unique case (st_ff.phase)
      fdp_pkg::BUS_RD_WAIT: begin
        nxt_st.rdata = read_word(st_ff, st_ff.addr);
        nxt_st.phase = fdp_pkg::BUS_RD_DONE;
      end
      fdp_pkg::BUS_IDLE, fdp_pkg::BUS_WRITE, fdp_pkg::BUS_RD_DONE: begin
        if (accept) begin
          nxt_st.addr  = HADDR[11:0];
          nxt_st.phase = HWRITE ? fdp_pkg::BUS_WRITE : fdp_pkg::BUS_RD_WAIT;
        end else begin
          nxt_st.phase = fdp_pkg::BUS_IDLE;
        end
      end
    endcase

    // hardware events come after the clear so a same-cycle set wins
    if (TX_OVERFLOW) begin
      nxt_st.status.tx_buffer_overflow = 1'b1;
    end
    if (INSERT_DONE) begin
      nxt_st.status.insertion_done = 1'b1;
      nxt_st.insert_en             = 1'b0;
    end

    nxt_st.irq = |(nxt_st.status & nxt_st.enable);

    // filter off: everything passes to buffer 0 untagged; on: only hits pass
    nxt_st.route_valid = STRM_VALID && (!st_ff.filter_en || match.hit);
    nxt_st.route_hit   = STRM_VALID && st_ff.filter_en && match.hit;
    nxt_st.route_buf   = (st_ff.filter_en && match.hit) ?
                         st_ff.buf_select[match.loc] : 3'h0;
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign HREADYOUT          = st_ff.phase != fdp_pkg::BUS_RD_WAIT;
  assign HRESP              = 1'b0;
  assign HRDATA             = st_ff.rdata;
  assign ROUTE_VALID        = st_ff.route_valid;
  assign ROUTE_BUF          = st_ff.route_buf;
  assign ROUTE_HIT          = st_ff.route_hit;
  assign INSERT_EN          = st_ff.insert_en;
  assign FILTER_EN          = st_ff.filter_en;
  assign SUMMARY_PORT_A_IRQ = st_ff.irq;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  irq_insert_done_a: assert property (
    INSERT_DONE && st_ff.enable.insertion_done && st_ff.phase != fdp_pkg::BUS_WRITE
      |=> SUMMARY_PORT_A_IRQ && st_ff.status.insertion_done)
    else $error("insertion done with enable did not raise irq");

  irq_overflow_a: assert property (
    TX_OVERFLOW && st_ff.enable.tx_buffer_overflow && st_ff.phase != fdp_pkg::BUS_WRITE
      |=> SUMMARY_PORT_A_IRQ)
    else $error("overflow with enable did not raise irq");

  irq_masked_quiet_a: assert property (
    (st_ff.status & st_ff.enable) == 2'b00 |-> !SUMMARY_PORT_A_IRQ)
    else $error("irq high without an enabled flag");

  masked_miss_drop_a: assert property (
    STRM_VALID && st_ff.filter_en && st_ff.mask == 32'hffff_ffff
      && STRM_ID != st_ff.loc_value[0] && STRM_ID != st_ff.loc_value[1]
      && STRM_ID != st_ff.loc_value[2] && STRM_ID != st_ff.loc_value[3]
      && STRM_ID != st_ff.loc_value[4] && STRM_ID != st_ff.loc_value[5]
      && STRM_ID != st_ff.loc_value[6] && STRM_ID != st_ff.loc_value[7]
      |=> !ROUTE_VALID)
    else $error("unmatched identifier passed the full mask");

  zero_mask_pass_a: assert property (
    STRM_VALID && st_ff.mask == 32'h0000_0000 |=> ROUTE_VALID)
    else $error("identifier dropped with an empty mask");

  map_field_pos_a: assert property (
    st_ff.phase == fdp_pkg::BUS_WRITE && st_ff.addr == `OFS_BUFFER_MAP
      |=> st_ff.buf_select[7] == $past(HWDATA[30:28])
          && st_ff.buf_select[0] == $past(HWDATA[2:0]))
    else $error("buffer select field landed in the wrong bits");

  loc0_route_a: assert property (
    STRM_VALID && st_ff.filter_en
      && ((STRM_ID ^ st_ff.loc_value[0]) & st_ff.mask) == 32'h0000_0000
      |=> ROUTE_VALID && ROUTE_HIT && ROUTE_BUF == $past(st_ff.buf_select[0]))
    else $error("location 0 hit not routed to its buffer");

  reserved_zero_a: assert property (
    st_ff.phase == fdp_pkg::BUS_RD_DONE
      && (st_ff.addr == `OFS_EVENT_ENABLE || st_ff.addr == `OFS_EVENT_STATUS)
      |-> HRDATA[31:9] == 23'h0 && HRDATA[7:1] == 7'h0)
    else $error("reserved bits read non-zero");

  overflow_flag_a: assert property (
    TX_OVERFLOW |=> st_ff.status.tx_buffer_overflow [*2] or
      ($past(st_ff.phase) == fdp_pkg::BUS_WRITE || st_ff.phase == fdp_pkg::BUS_WRITE))
    else $error("overflow flag not held after the event");

  inserter_off_a: assert property (
    INSERT_DONE |=> !INSERT_EN && st_ff.status.insertion_done)
    else $error("inserter still enabled after insertion done");

  read_wait_a: assert property (
    accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read did not answer after one wait state");

  write_no_wait_a: assert property (
    accept && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");

  reset_idle_a: assert property (
    !$past(NRST) |-> HREADYOUT && !ROUTE_VALID && !INSERT_EN && !FILTER_EN
      && !SUMMARY_PORT_A_IRQ && HRDATA == `WORD_RESET)
    else $error("outputs not idle after reset");

  overflow_w1c_a: assert property (
    st_ff.phase == fdp_pkg::BUS_WRITE && st_ff.addr == `OFS_EVENT_STATUS
      && HWDATA[`BIT_TX_OVERFLOW] && !TX_OVERFLOW
      |=> !st_ff.status.tx_buffer_overflow)
    else $error("overflow flag not cleared by writing one");

  insert_w1c_a: assert property (
    st_ff.phase == fdp_pkg::BUS_WRITE && st_ff.addr == `OFS_EVENT_STATUS
      && HWDATA[`BIT_INSERT_DONE] && !INSERT_DONE
      |=> !st_ff.status.insertion_done)
    else $error("insertion done flag not cleared by writing one");

  loc_frozen_a: assert property (
    st_ff.filter_en |=> $stable(st_ff.loc_value))
    else $error("location value changed while the filter ran");

  lowest_match_a: assert property (
    STRM_VALID && st_ff.filter_en
      && ((STRM_ID ^ st_ff.loc_value[0]) & st_ff.mask) != 32'h0000_0000
      && ((STRM_ID ^ st_ff.loc_value[1]) & st_ff.mask) == 32'h0000_0000
      |=> ROUTE_HIT && ROUTE_BUF == $past(st_ff.buf_select[1]))
    else $error("location 1 hit not routed to its buffer");

  filter_off_pass_a: assert property (
    STRM_VALID && !st_ff.filter_en |=> ROUTE_VALID && !ROUTE_HIT && ROUTE_BUF == 3'h0)
    else $error("identifier not passed untagged with the filter off");

  stream_idle_quiet_a: assert property (
    !STRM_VALID |=> !ROUTE_VALID && !ROUTE_HIT)
    else $error("route output without an identifier");

  map_reserved_a: assert property (
    st_ff.phase == fdp_pkg::BUS_RD_DONE && st_ff.addr == `OFS_BUFFER_MAP
      |-> (HRDATA & 32'h8888_8888) == 32'h0000_0000)
    else $error("buffer map reserved bits read non-zero");

  cover_route_hit_c:   cover property (STRM_VALID && st_ff.filter_en ##1 ROUTE_HIT);
  cover_irq_c:         cover property (!SUMMARY_PORT_A_IRQ ##1 SUMMARY_PORT_A_IRQ);
  cover_w1c_c:         cover property (SUMMARY_PORT_A_IRQ ##[1:20] !SUMMARY_PORT_A_IRQ);
  cover_insert_stop_c: cover property (INSERT_EN ##1 !INSERT_EN);

endmodule

// >>> verilog/fdp_consts.svh
// offsets, field positions and reset values of the port a filter and event registers
`ifndef FDP_CONSTS_SVH
`define FDP_CONSTS_SVH

`define OFS_EVENT_STATUS   12'h088
`define OFS_EVENT_ENABLE   12'h08c
`define OFS_FILTER_MASK    12'h090
`define OFS_BUFFER_MAP     12'h094
`define OFS_FILTER_CTRL    12'h0a4
`define OFS_LOC_BASE       12'h0c0

`define BIT_INSERT_DONE    8
`define BIT_TX_OVERFLOW    0
`define MAP_FIELD_STRIDE   4
`define MAP_FIELD_WIDTH    3
`define CTRL_FILTER_EN     0
`define CTRL_INSERT_EN     1

`define WORD_RESET         32'h0000_0000
`define UNMAPPED_READ      32'h0000_0000

`endif

// >>> verilog/fdp_pkg.sv
// types shared by the port a filter and event register block
package fdp_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } bus_phase_t;

  typedef struct packed {
    logic insertion_done;
    logic tx_buffer_overflow;
  } event_bits_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] loc;
  } match_result_t;

  typedef struct packed {
    bus_phase_t        phase;
    logic [11:0]       addr;
    logic [31:0]       rdata;
    event_bits_t       enable;
    event_bits_t       status;
    logic [31:0]       mask;
    logic [7:0][2:0]   buf_select;
    logic [7:0][31:0]  loc_value;
    logic              filter_en;
    logic              insert_en;
    logic              irq;
    logic              route_valid;
    logic [2:0]        route_buf;
    logic              route_hit;
  } state_t;

endpackage

// >>> verilog/stream_id_matcher.sv
// masked compare of one stream identifier against eight filter locations
`timescale 1ns/1ns

module stream_id_matcher (
  input  wire logic [31:0]      stream_id,
  input  wire logic [31:0]      mask,
  input  wire logic [7:0][31:0] loc_value,
  output fdp_pkg::match_result_t result
);

  logic [7:0] loc_hit;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_loc
      // only bits set in the mask take part; an all-zero mask hits everywhere
      assign loc_hit[g] = ((stream_id ^ loc_value[g]) & mask) == 32'h0000_0000;
    end
  endgenerate

  // scan from the top so the lowest matching location is the last one kept
  always_comb begin
    result = '0;
    for (int i = 7; i >= 0; i--) begin
      if (loc_hit[i]) begin
        result.hit = 1'b1;
        result.loc = 3'(i);
      end
    end
  end

endmodule

// >>> tb/fdp_app_model.sv
// application side model: identifier source and event pulse generator
`timescale 1ns/1ns

module fdp_app_model (
  input  wire logic        clk,
  output logic             strm_valid,
  output logic      [31:0] strm_id,
  output logic             tx_overflow,
  output logic             insert_done
);
  initial begin
    strm_valid  = 1'b0;
    strm_id     = 32'h0000_0000;
    tx_overflow = 1'b0;
    insert_done = 1'b0;
  end
  // caller sits just after a rising edge; back to back calls hold valid up
  task automatic send(input logic [31:0] id);
    strm_valid <= 1'b1;
    strm_id    <= id;
    @(posedge clk);
  endtask
  // an idle line must not repeat the last identifier
  task automatic idle();
    strm_valid <= 1'b0;
    strm_id    <= ~strm_id;
    @(posedge clk);
  endtask
  task automatic pulse(input logic ovf, input logic done);
    tx_overflow <= ovf;
    insert_done <= done;
    @(posedge clk);
    tx_overflow <= 1'b0;
    insert_done <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// >>> tb/fast_data_port_a_regs_tb.sv
// self-checking bench for the port a filter and event register block
`timescale 1ns/1ns
`include "fdp_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end

module fast_data_port_a_regs_tb;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'b00;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, STRM_ID, d, m;
  logic        HREADYOUT, ROUTE_VALID, ROUTE_HIT, INSERT_EN, FILTER_EN, SUMMARY_PORT_A_IRQ;
  logic        STRM_VALID, TX_OVERFLOW, INSERT_DONE, HRESP, fen = 1'b0, rd_dp = 1'b0;
  logic [2:0]  ROUTE_BUF;
  logic [3:0]  rt_q[$], r4;
  logic [31:0] rd_q[$], locs[8], msk = 32'h0, map = 32'h0;
  logic [11:0] regs[6] = '{`OFS_EVENT_STATUS, `OFS_EVENT_ENABLE, `OFS_FILTER_MASK,
                           `OFS_BUFFER_MAP, `OFS_FILTER_CTRL, 12'h0f0};
  int          error_cnt = 0;
  int          n_checks = 0;

  always #20 CLK = ~CLK;

  fast_data_port_a_regs dut (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .STRM_VALID(STRM_VALID),
    .STRM_ID(STRM_ID), .TX_OVERFLOW(TX_OVERFLOW), .INSERT_DONE(INSERT_DONE),
    .ROUTE_VALID(ROUTE_VALID), .ROUTE_BUF(ROUTE_BUF), .ROUTE_HIT(ROUTE_HIT),
    .INSERT_EN(INSERT_EN), .FILTER_EN(FILTER_EN), .SUMMARY_PORT_A_IRQ(SUMMARY_PORT_A_IRQ));
  fdp_app_model src (.clk(CLK), .strm_valid(STRM_VALID), .strm_id(STRM_ID),
    .tx_overflow(TX_OVERFLOW), .insert_done(INSERT_DONE));

  ////////////////////////////////////////
  // ready is read at the edge itself, before that edge's updates land
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 20);
    if (n == 20) `CHK(HREADYOUT, 1'b1)
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HADDR  <= {20'h0, a};
    HWRITE <= wr;
    wait_rdy();
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_rdy();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, $urandom);
  endtask
  // {passed, hit, buffer}; walking down leaves the lowest match in place
  function automatic logic [4:0] route_of(input logic [31:0] id);
    route_of = {~fen, 4'h0};
    for (int i = 7; i >= 0; i--)
      if (fen && ((id ^ locs[i]) & msk) == 32'h0) route_of = {2'b11, map[4 * i +: 3]};
  endfunction
  task automatic stream(input int n);
    logic [31:0] id;
    logic [4:0]  r;
    for (int k = 0; k < n; k++) begin
      id = k[0] ? locs[$urandom_range(7)] ^ ($urandom & ~msk) : $urandom;
      r = route_of(id);
      if (r[4]) rt_q.push_back(r[3:0]);
      src.send(id);
    end
    src.idle();
    repeat (2) @(posedge CLK);
    `CHK(FILTER_EN, fen)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  always @(posedge CLK) begin
    if (HREADYOUT === 1'b1) begin
      if (rd_dp) begin
        m = rd_q.pop_front();
        `CHK({HRESP, HRDATA}, {1'b0, m})
      end
      rd_dp = HSEL & HTRANS[1] & ~HWRITE;
    end
    if (ROUTE_VALID === 1'b1) begin
      r4 = rt_q.size() > 0 ? rt_q.pop_front() : 4'hx;
      `CHK({ROUTE_HIT, ROUTE_BUF}, r4)
    end
  end

  initial begin
    void'($urandom(48));
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    foreach (regs[i]) rd(regs[i], 32'h0);
    bus(1'b1, `OFS_EVENT_ENABLE, 32'hffff_ffff);
    rd(`OFS_EVENT_ENABLE, 32'h0000_0101);
    d = $urandom;
    bus(1'b1, `OFS_BUFFER_MAP, d);
    map = d & 32'h7777_7777;
    rd(`OFS_BUFFER_MAP, map);
    for (int i = 0; i < 8; i++) begin
      locs[i] = (i == 5) ? locs[2] : $urandom; // two locations share a value
      bus(1'b1, `OFS_LOC_BASE + 12'(4 * i), locs[i]);
      rd(`OFS_LOC_BASE + 12'(4 * i), locs[i]);
    end
    $display("test registers done");
    fen = 1'b1;
    bus(1'b1, `OFS_FILTER_CTRL, 32'h1);
    // a running filter must refuse location writes
    bus(1'b1, `OFS_LOC_BASE, ~locs[0]);
    rd(`OFS_LOC_BASE, locs[0]);
    for (int j = 0; j < 3; j++) begin
      msk = (j == 0) ? $urandom : (j == 1) ? 32'hffff_ffff : 32'h0;
      bus(1'b1, `OFS_FILTER_MASK, msk);
      rd(`OFS_FILTER_MASK, msk);
      stream(16);
    end
    fen = 1'b0;
    bus(1'b1, `OFS_FILTER_CTRL, 32'h0);
    stream(8);
    $display("test routing done");
    for (int e = 0; e < 2; e++) begin
      d = e[0] ? 32'h100 : 32'h001;
      bus(1'b1, `OFS_EVENT_ENABLE, d ^ 32'h101);
      bus(1'b1, `OFS_FILTER_CTRL, 32'h2);
      src.pulse(~e[0], e[0]);
      rd(`OFS_EVENT_STATUS, d);
      `CHK(SUMMARY_PORT_A_IRQ, 1'b0)
      `CHK(INSERT_EN, ~e[0])
      bus(1'b1, `OFS_EVENT_STATUS, d);
      bus(1'b1, `OFS_EVENT_ENABLE, d);
      src.pulse(~e[0], e[0]);
      repeat (2) @(posedge CLK);
      `CHK(SUMMARY_PORT_A_IRQ, 1'b1)
      bus(1'b1, `OFS_EVENT_STATUS, d);
      rd(`OFS_EVENT_STATUS, 32'h0);
      `CHK(SUMMARY_PORT_A_IRQ, 1'b0)
    end
    $display("test events done");
    // let the monitor take the last read before the queues are counted
    repeat (2) @(posedge CLK);
    `CHK(rt_q.size() + rd_q.size(), 0)
    complete_run();
  end

  // the full run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK);
    error_cnt++;
    complete_run();
  end
endmodule
